// ### design/aesr_pkg.sv
// constants shared by the cipher service engine and its byte queues
// assumes one 50 MHz clock and a byte-wide memory slave outside
package aesr_pkg;
  localparam logic [7:0]  CMD_AES128      = 8'h03;
  localparam logic [7:0]  CMD_AES256      = 8'h06;
  localparam logic [7:0]  ST_SUCCESS      = 8'h00;
  localparam logic [7:0]  ST_BUS_ERROR    = 8'h7F;
  localparam logic [7:0]  ST_NOT_LICENSED = 8'hFD;
  localparam logic [7:0]  ST_FACTORY_OFF  = 8'hFE;
  localparam logic [7:0]  ST_USER_OFF     = 8'hFF;
  // descriptor layout, byte offsets for the short-key form
  localparam int          DESC_LEN        = 44;
  localparam int          KEY_OFS         = 0;
  localparam int          KEY_LEN         = 16;
  localparam int          LONG_KEY_EXTRA  = 16;
  localparam int          IV_OFS          = 16;
  localparam int          NBLK_OFS        = 32;
  localparam int          MODE_OFS        = 34;
  localparam int          DST_OFS         = 36;
  localparam int          SRC_OFS         = 40;
  localparam int          DECRYPT_BIT     = 7;
  localparam int          DESC_MAX        = DESC_LEN + LONG_KEY_EXTRA;
  // chaining mode field encodings
  localparam logic [1:0]  MODE_CODEBOOK   = 2'h0;
  localparam logic [1:0]  MODE_CHAIN      = 2'h1;
  localparam logic [1:0]  MODE_OUT_FB     = 2'h2;
  localparam logic [1:0]  MODE_COUNTER    = 2'h3;
  localparam int          BLOCK_BYTES     = 16;
  localparam int          PTR_BYTES       = 4;
  localparam int          RSP_BYTES       = 6;
  localparam int          QUEUE_DEPTH     = 8;
  // channel interrupt enable word
  localparam logic [31:0] IRQ_EN_ADDR     = 32'h40006000;
  localparam int          IRQ_EN_BIT      = 29;
  localparam logic [31:0] IRQ_EN_RESET    = 32'h00000000;
  typedef enum logic [3:0] {
    AESR_IDLE, AESR_PTR, AESR_CHECK, AESR_FETCH, AESR_DECODE,
    AESR_RD, AESR_CORE, AESR_WR, AESR_RSP
  } aesr_state_e;
endpackage

// ### design/aesr_byte_queue.sv
// shift-register byte queue with registered head and full flags
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module aesr_byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  full,
  output logic                  head_valid,
  output logic      [WIDTH-1:0] head_data,
  input  wire logic             head_pop
);
  logic [WIDTH-1:0] data_q [DEPTH];
  logic [WIDTH-1:0] data_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic             pop;
  logic             push;
  logic             placed;

  assign pop        = head_pop & vld_q[0];
  assign push       = in_valid & ~vld_q[DEPTH-1];
  assign full       = vld_q[DEPTH-1];
  assign head_valid = vld_q[0];
  assign head_data  = data_q[0];

  // shift on pop, then drop the new byte in the first empty slot
  always_comb begin
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH-1) begin
        data_d[i] = data_q[i+1];
        vld_d[i]  = vld_q[i+1];
      end else if (pop) begin
        data_d[i] = data_q[i];
        vld_d[i]  = 1'b0;
      end else begin
        data_d[i] = data_q[i];
        vld_d[i]  = vld_q[i];
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !vld_d[i]) begin
        data_d[i] = in_data;
        vld_d[i]  = 1'b1;
        placed    = 1'b1;
      end
    end
  end

  // slot storage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      vld_q <= '0;
    end else begin
      vld_q <= vld_d;
    end
    for (int i = 0; i < DEPTH; i++) begin
      data_q[i] <= data_d[i];
    end
  end
endmodule

// ### design/aesr_service_engine.sv
// cipher service engine: takes channel commands, fetches the descriptor
// and data, drives the cipher core, writes results, returns a status
// assumes a byte-wide memory slave and a cipher core outside
`timescale 1ns/1ps
module aesr_service_engine (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_byte,
  output logic              cmd_full,
  output logic              receive_ready_flag,
  output logic [7:0]        rsp_byte,
  input  wire logic         rsp_pop,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [31:0]  reg_addr,
  input  wire logic [31:0]  reg_wdata,
  output logic [31:0]       reg_rdata_q,
  output logic              channel_interrupt_q,
  output logic              mem_req_q,
  output logic              mem_we_q,
  output logic [31:0]       mem_addr_q,
  output logic [7:0]        mem_wdata_q,
  input  wire logic [7:0]   mem_rdata,
  input  wire logic         mem_ack,
  input  wire logic         mem_err,
  output logic              core_start_q,
  output logic              core_first_q,
  output logic              core_decrypt_q,
  output logic [1:0]        core_mode_q,
  output logic              core_long_key_q,
  output logic [255:0]      core_key_q,
  output logic [127:0]      core_iv_q,
  output logic [127:0]      core_din_q,
  input  wire logic [127:0] core_dout,
  input  wire logic         core_done,
  input  wire logic         service_licensed,
  input  wire logic         factory_disable,
  input  wire logic         user_disable
);
  import aesr_pkg::*;
  aesr_state_e state_q;
  logic [7:0]  desc_q [DESC_MAX];
  logic [7:0]  cmd_q;
  logic [7:0]  status_q;
  logic [31:0] ptr_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic [15:0] blk_left_q;
  logic [127:0] dout_q;
  logic [5:0]  idx_q;
  logic [31:0] irq_en_q;
  logic [2:0]  sec_meta_q;
  logic [2:0]  sec_sync_q;
  logic        cq_valid;
  logic [7:0]  cq_byte;
  logic        cq_pop;
  logic        rq_push;
  logic [7:0]  rq_byte;
  logic [5:0]  desc_last;
  int          kx;
  logic        rq_full;
  // command queue, requester to engine
  aesr_byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_cmd_queue (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .in_valid   (cmd_valid),
    .in_data    (cmd_byte),
    .full       (cmd_full),
    .head_valid (cq_valid),
    .head_data  (cq_byte),
    .head_pop   (cq_pop)
  );
  // response queue, engine to requester; head valid is the ready flag
  aesr_byte_queue #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_rsp_queue (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .in_valid   (rq_push),
    .in_data    (rq_byte),
    .full       (rq_full),
    .head_valid (receive_ready_flag),
    .head_data  (rsp_byte),
    .head_pop   (rsp_pop)
  );
  // straps pass two flip-flops before use
  always_ff @(posedge ref_clk) begin
    sec_meta_q <= {user_disable, factory_disable, service_licensed};
    sec_sync_q <= sec_meta_q;
  end
  // interrupt enable word and its read port
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_en_q            <= IRQ_EN_RESET;
      reg_rdata_q         <= 32'h00000000;
      channel_interrupt_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == IRQ_EN_ADDR) begin
        irq_en_q <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata_q <= (reg_addr == IRQ_EN_ADDR) ? irq_en_q : 32'h00000000;
      end
      channel_interrupt_q <= irq_en_q[IRQ_EN_BIT] & receive_ready_flag;
    end
  end
  // queue handshakes and response byte order
  assign cq_pop  = cq_valid && (state_q == AESR_IDLE || state_q == AESR_PTR);
  assign rq_push = (state_q == AESR_RSP);
  assign kx      = (cmd_q == CMD_AES256) ? LONG_KEY_EXTRA : 0;
  assign desc_last = 6'(DESC_LEN + kx - 1);
  always_comb begin
    if (idx_q == 6'h0) begin
      rq_byte = cmd_q;
    end else if (idx_q == 6'h1) begin
      rq_byte = status_q;
    end else begin
      rq_byte = ptr_q[8*(idx_q-6'h2) +: 8];
    end
  end
  // service sequencer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q         <= AESR_IDLE;
      cmd_q           <= 8'h00;
      status_q        <= ST_SUCCESS;
      idx_q           <= 6'h0;
      mem_req_q       <= 1'b0;
      mem_we_q        <= 1'b0;
      mem_addr_q      <= 32'h00000000;
      mem_wdata_q     <= 8'h00;
      core_start_q    <= 1'b0;
      core_first_q    <= 1'b0;
      core_decrypt_q  <= 1'b0;
      core_mode_q     <= MODE_CODEBOOK;
      core_long_key_q <= 1'b0;
      core_key_q      <= '0;
      core_iv_q       <= '0;
      core_din_q      <= '0;
    end else begin
      case (state_q)
        AESR_IDLE: begin
          // unknown command bytes are dropped
          if (cq_valid && (cq_byte == CMD_AES128 || cq_byte == CMD_AES256))
          begin
            cmd_q <= cq_byte;
            idx_q <= 6'h0;
            state_q <= AESR_PTR;
          end
        end
        AESR_PTR: begin
          if (cq_valid) begin
            ptr_q[8*idx_q[1:0] +: 8] <= cq_byte;
            idx_q <= idx_q + 6'h1;
            if (idx_q == 6'(PTR_BYTES - 1)) begin
              state_q <= AESR_CHECK;
            end
          end
        end
        AESR_CHECK: begin
          idx_q <= 6'h0;
          if (sec_sync_q[1]) begin
            status_q <= ST_FACTORY_OFF;
            state_q  <= AESR_RSP;
          end else if (sec_sync_q[2]) begin
            status_q <= ST_USER_OFF;
            state_q  <= AESR_RSP;
          end else if (!sec_sync_q[0]) begin
            status_q <= ST_NOT_LICENSED;
            state_q  <= AESR_RSP;
          end else begin
            status_q <= ST_SUCCESS;
            state_q  <= AESR_FETCH;
          end
        end
        AESR_FETCH: begin
          // read the descriptor one byte at a time
          if (!mem_req_q) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= 1'b0;
            mem_addr_q <= ptr_q + {26'h0, idx_q};
          end else if (mem_err) begin
            mem_req_q <= 1'b0;
            status_q  <= ST_BUS_ERROR;
            idx_q     <= 6'h0;
            state_q   <= AESR_RSP;
          end else if (mem_ack) begin
            mem_req_q     <= 1'b0;
            desc_q[idx_q] <= mem_rdata;
            idx_q         <= idx_q + 6'h1;
            if (idx_q == desc_last) begin
              state_q <= AESR_DECODE;
            end
          end
        end
        AESR_DECODE: begin
          for (int i = 0; i < 32; i++) begin
            core_key_q[8*i +: 8] <= (i < KEY_LEN + kx) ?
                                    desc_q[KEY_OFS + i] : 8'h00;
          end
          for (int i = 0; i < BLOCK_BYTES; i++) begin
            core_iv_q[8*i +: 8] <=
              (desc_q[MODE_OFS + kx][1:0] == MODE_CODEBOOK) ?
              8'h00 : desc_q[IV_OFS + kx + i];
          end
          for (int i = 0; i < PTR_BYTES; i++) begin
            dst_q[8*i +: 8] <= desc_q[DST_OFS + kx + i];
            src_q[8*i +: 8] <= desc_q[SRC_OFS + kx + i];
          end
          blk_left_q <= {desc_q[NBLK_OFS + kx + 1],
                         desc_q[NBLK_OFS + kx]};
          core_decrypt_q  <= desc_q[MODE_OFS + kx][DECRYPT_BIT];
          core_mode_q     <= desc_q[MODE_OFS + kx][1:0];
          core_long_key_q <= (cmd_q == CMD_AES256);
          core_first_q    <= 1'b1;
          idx_q           <= 6'h0;
          if ({desc_q[NBLK_OFS + kx + 1], desc_q[NBLK_OFS + kx]} == 16'h0)
          begin
            state_q <= AESR_RSP;
          end else begin
            state_q <= AESR_RD;
          end
        end
        AESR_RD: begin
          // gather one block from the source buffer
          if (!mem_req_q) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= 1'b0;
            mem_addr_q <= src_q;
          end else if (mem_err) begin
            mem_req_q <= 1'b0;
            status_q  <= ST_BUS_ERROR;
            idx_q     <= 6'h0;
            state_q   <= AESR_RSP;
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            core_din_q[8*idx_q[3:0] +: 8] <= mem_rdata;
            src_q <= src_q + 32'h1;
            idx_q <= idx_q + 6'h1;
            if (idx_q == 6'(BLOCK_BYTES - 1)) begin
              core_start_q <= 1'b1;
              state_q      <= AESR_CORE;
            end
          end
        end
        AESR_CORE: begin
          core_start_q <= 1'b0;
          idx_q        <= 6'h0;
          if (core_done && !core_start_q) begin
            dout_q  <= core_dout;
            state_q <= AESR_WR;
          end
        end
        AESR_WR: begin
          // write the block to the result buffer
          if (!mem_req_q) begin
            mem_req_q   <= 1'b1;
            mem_we_q    <= 1'b1;
            mem_addr_q  <= dst_q;
            mem_wdata_q <= dout_q[8*idx_q[3:0] +: 8];
          end else if (mem_err) begin
            mem_req_q <= 1'b0;
            status_q  <= ST_BUS_ERROR;
            idx_q     <= 6'h0;
            state_q   <= AESR_RSP;
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            dst_q     <= dst_q + 32'h1;
            idx_q     <= idx_q + 6'h1;
            if (idx_q == 6'(BLOCK_BYTES - 1)) begin
              core_first_q <= 1'b0;
              blk_left_q   <= blk_left_q - 16'h1;
              idx_q        <= 6'h0;
              if (blk_left_q == 16'h1) begin
                state_q <= AESR_RSP;
              end else begin
                state_q <= AESR_RD;
              end
            end
          end
        end
        AESR_RSP: begin
          // one response byte per cycle while the queue has room
          if (!rq_full) begin
            idx_q <= idx_q + 6'h1;
            if (idx_q == 6'(RSP_BYTES - 1)) begin
              idx_q   <= 6'h0;
              state_q <= AESR_IDLE;
            end
          end
        end
        default: begin
          state_q <= AESR_IDLE;
        end
      endcase
    end
  end
endmodule

// ### bench/aesr_service_engine_props.sv
// port checker for the cipher service engine
// assumes it is bound onto aesr_service_engine, one clock domain
`timescale 1ns/1ps
module aesr_checker
  import aesr_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         reset_n,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic [31:0]  reg_rdata_q,
  input wire logic         channel_interrupt_q,
  input wire logic         receive_ready_flag,
  input wire logic [7:0]   rsp_byte,
  input wire logic         rsp_pop,
  input wire logic         mem_req_q,
  input wire logic         mem_we_q,
  input wire logic [31:0]  mem_addr_q,
  input wire logic         mem_ack,
  input wire logic         mem_err,
  input wire logic         core_start_q,
  input wire logic [1:0]   core_mode_q,
  input wire logic [127:0] core_iv_q,
  input wire logic [127:0] core_din_q,
  input wire logic [255:0] core_key_q
);
  logic en_q;
  // shadow of the channel interrupt enable bit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) en_q <= 1'b0;
    else if (reg_wr && reg_addr == IRQ_EN_ADDR) en_q <= reg_wdata[IRQ_EN_BIT];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_irq_follows_flag: assert property (
    1 |=> channel_interrupt_q == $past(en_q && receive_ready_flag))
    else $error("interrupt does not follow enabled ready flag");
  a_unmapped_reads_zero: assert property (
    reg_rd && reg_addr != IRQ_EN_ADDR |=> reg_rdata_q == 32'h0)
    else $error("unmapped read not zero");
  a_iv_ignored_codebook: assert property (
    core_start_q && core_mode_q == MODE_CODEBOOK |-> core_iv_q == 128'h0)
    else $error("vector used in codebook mode");
  a_req_holds_steady: assert property (
    mem_req_q && !mem_ack && !mem_err
      |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
    else $error("memory request changed before answer");
  a_req_drops_answer: assert property (
    mem_req_q && (mem_ack || mem_err) |=> !mem_req_q)
    else $error("memory request kept after answer");
  a_start_one_pulse: assert property (
    core_start_q |=> !core_start_q)
    else $error("core start longer than one cycle");
  a_block_in_stable: assert property (
    core_start_q |=> $stable(core_din_q) && $stable(core_key_q))
    else $error("core inputs moved during a block");
  a_rsp_head_stands: assert property (
    receive_ready_flag && !rsp_pop |=> receive_ready_flag && $stable(rsp_byte))
    else $error("response head changed without pop");
  c_block_run: cover property (core_start_q);
  c_bus_error: cover property (mem_req_q && mem_err);
  c_irq_seen: cover property (channel_interrupt_q);
endmodule

bind aesr_service_engine aesr_checker chk (.ref_clk, .reset_n, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .channel_interrupt_q,
  .receive_ready_flag, .rsp_byte, .rsp_pop, .mem_req_q, .mem_we_q,
  .mem_addr_q, .mem_ack, .mem_err, .core_start_q, .core_mode_q, .core_iv_q,
  .core_din_q, .core_key_q);

// ### bench/aesr_partner.sv
// far side model: byte memory slave and a stand-in cipher core
// assumes the engine's registered byte master and start/done handshake
`timescale 1ns/1ps
module aesr_partner
  import aesr_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         mem_req_q,
  input  wire logic         mem_we_q,
  input  wire logic [31:0]  mem_addr_q,
  input  wire logic [7:0]   mem_wdata_q,
  output logic [7:0]        mem_rdata,
  output logic              mem_ack,
  output logic              mem_err,
  input  wire logic         core_start_q,
  input  wire logic         core_decrypt_q,
  input  wire logic [1:0]   core_mode_q,
  input  wire logic [255:0] core_key_q,
  input  wire logic [127:0] core_din_q,
  output logic [127:0]      core_dout,
  output logic              core_done
);
  logic [7:0] mem [0:1023];
  logic [1:0] wait_q;
  logic       slow_q, busy_q, dec_seen;
  logic [1:0] mode_seen;
  // memory: answers alternate prompt and slow, high address bit faults
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata; // idle data lines do not hold their value
    if (!reset_n) begin
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      mem_rdata <= 8'h5A;
    end else if (mem_req_q && !mem_ack && !mem_err) begin
      if (wait_q != {slow_q, slow_q}) wait_q <= wait_q + 2'h1;
      else begin
        wait_q <= 2'h0;
        slow_q <= !slow_q;
        if (mem_addr_q[31]) mem_err <= 1'b1;
        else begin
          mem_ack <= 1'b1;
          if (mem_we_q) mem[mem_addr_q[9:0]] <= mem_wdata_q;
          else mem_rdata <= mem[mem_addr_q[9:0]];
        end
      end
    end
  end
  // core: xor with both key halves, done two edges after start
  always @(posedge ref_clk) begin
    core_done <= 1'b0;
    if (!reset_n) busy_q <= 1'b0;
    else if (core_start_q) begin
      busy_q <= 1'b1;
      dec_seen <= core_decrypt_q;
      mode_seen <= core_mode_q;
      core_dout <= core_din_q ^ core_key_q[127:0] ^ core_key_q[255:128];
    end else if (busy_q) begin
      busy_q <= 1'b0;
      core_done <= 1'b1;
    end
  end
endmodule

// ### bench/test_aes_service_request_master.sv
// self-checking bench for the cipher service engine
// assumes aesr_partner as memory and core, checker bound by its own file
`timescale 1ns/1ps
module test_aes_service_request_master;
  import aesr_pkg::*;
  localparam logic [31:0] DP = 32'h00000100;
  localparam logic [31:0] SA = 32'h00000200;
  localparam logic [31:0] DA = 32'h00000300;
  logic         ref_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0;
  logic [7:0]   cmd_byte = 8'h00;
  logic         rsp_pop = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0]  reg_addr = 32'h0, reg_wdata = 32'h0;
  logic         service_licensed = 1'b1, factory_disable = 1'b0;
  logic         user_disable = 1'b0;
  logic         cmd_full, receive_ready_flag, channel_interrupt_q;
  logic [7:0]   rsp_byte, mem_wdata_q, mem_rdata;
  logic [31:0]  reg_rdata_q, mem_addr_q;
  logic         mem_req_q, mem_we_q, mem_ack, mem_err, core_start_q;
  logic         core_first_q, core_decrypt_q, core_long_key_q, core_done;
  logic [1:0]   core_mode_q;
  logic [255:0] core_key_q;
  logic [127:0] core_iv_q, core_din_q, core_dout;
  int           n_mismatch = 0;
  int           checked = 0;
  int           n_first = 0;
  int           m;

  always #10 ref_clk = ~ref_clk;

  // count blocks started as the first of their request
  always @(posedge ref_clk) if (core_start_q && core_first_q) n_first++;

  aesr_service_engine dut (.ref_clk, .reset_n, .cmd_valid, .cmd_byte,
    .cmd_full, .receive_ready_flag, .rsp_byte, .rsp_pop, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata_q, .channel_interrupt_q, .mem_req_q,
    .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_ack, .mem_err,
    .core_start_q, .core_first_q, .core_decrypt_q, .core_mode_q,
    .core_long_key_q, .core_key_q, .core_iv_q, .core_din_q, .core_dout,
    .core_done, .service_licensed, .factory_disable, .user_disable);
  aesr_partner mdl (.ref_clk, .reset_n, .mem_req_q, .mem_we_q, .mem_addr_q,
    .mem_wdata_q, .mem_rdata, .mem_ack, .mem_err, .core_start_q,
    .core_decrypt_q, .core_mode_q, .core_key_q, .core_din_q, .core_dout,
    .core_done);

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // one register pulse, read data settled two falling edges later
  task automatic reg_access(input logic wr, input logic [31:0] a, d);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge ref_clk);
  endtask

  // build a descriptor, send the command, check response and results
  task automatic run(input logic [7:0] cmd, md, input logic [15:0] nb,
                     input logic [31:0] sp, input logic [7:0] st);
    int o, k, n, f;
    logic [7:0] r [6];
    logic [7:0] e;
    o = (cmd == CMD_AES256) ? LONG_KEY_EXTRA : 0;
    for (k = 0; k < 60; k++) mdl.mem[DP + k] = 8'hA0 + k[7:0];
    mdl.mem[DP + NBLK_OFS + o] = nb[7:0];
    mdl.mem[DP + NBLK_OFS + o + 1] = nb[15:8];
    mdl.mem[DP + MODE_OFS + o] = md;
    for (k = 0; k < 4; k++) begin
      mdl.mem[DP + DST_OFS + o + k] = DA[8*k +: 8];
      mdl.mem[DP + SRC_OFS + o + k] = sp[8*k +: 8];
    end
    for (k = 0; k < 32; k++) begin
      mdl.mem[SA + k] = 8'h3C ^ k[7:0];
      mdl.mem[DA + k] = 8'hEE;
    end
    r[0] = cmd;
    r[1] = st;
    f = n_first;
    cmd_valid = 1'b1;
    cmd_byte = cmd;
    @(negedge ref_clk);
    for (k = 0; k < 4; k++) begin
      r[k + 2] = DP[8*k +: 8];
      cmd_byte = DP[8*k +: 8];
      @(negedge ref_clk);
    end
    if (st == ST_SUCCESS || st == ST_BUS_ERROR) begin
      // engine is busy fetching: junk fills the queue, dropped later
      cmd_byte = 8'h5A;
      repeat (8) @(negedge ref_clk);
      check(cmd_full, 1'b1);
    end
    cmd_valid = 1'b0;
    for (k = 0; k < 6; k++) begin
      n = 0;
      while (receive_ready_flag !== 1'b1 && n < 2000) begin
        @(negedge ref_clk);
        n++;
      end
      check(rsp_byte, r[k]);
      if (k == 0) begin
        @(negedge ref_clk);
        check(channel_interrupt_q, 1'b1);
      end
      rsp_pop = 1'b1;
      @(negedge ref_clk);
      rsp_pop = 1'b0;
      @(negedge ref_clk);
    end
    for (k = 0; k < 16 * ((nb == 0) ? 1 : nb); k++) begin
      e = 8'h3C ^ k[7:0] ^ (8'hA0 + k[3:0]) ^ (o ? 8'hB0 + k[3:0] : 8'h00);
      check(mdl.mem[DA + k], (st == ST_SUCCESS && nb != 0) ? e : 8'hEE);
    end
    if (st == ST_SUCCESS && nb != 0) begin
      check(mdl.mode_seen, md[1:0]);
      check(mdl.dec_seen, md[DECRYPT_BIT]);
      check(core_long_key_q, cmd == CMD_AES256);
      e = (md[1:0] == MODE_CODEBOOK) ? 8'h00 : 8'hB0 + o[7:0];
      check(core_iv_q[7:0], e);
    end
    check(n_first - f, (st == ST_SUCCESS && nb != 0) ? 1 : 0);
    $display("request %h mode %h blocks %0d done", cmd, md, nb);
  endtask

  // print the counts and the verdict, then stop
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    reg_access(1'b0, IRQ_EN_ADDR, 32'h0);
    check(reg_rdata_q, IRQ_EN_RESET);
    reg_access(1'b1, IRQ_EN_ADDR, 32'h20000000);
    reg_access(1'b0, IRQ_EN_ADDR, 32'h0);
    check(reg_rdata_q, 32'h20000000);
    reg_access(1'b0, 32'h40006004, 32'h0);
    check(reg_rdata_q, 32'h0);
    $display("register test done");
    cmd_valid = 1'b1;
    cmd_byte = 8'h5A;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    repeat (20) @(negedge ref_clk);
    check(receive_ready_flag, 1'b0);
    for (m = 0; m < 4; m++)
      run(m[0] ? CMD_AES256 : CMD_AES128, {m[0], m[1], 4'h0, m[1:0]},
          16'h1 + m[0], SA, ST_SUCCESS);
    run(CMD_AES128, 8'h01, 16'h0, SA, ST_SUCCESS);
    run(CMD_AES128, 8'h01, 16'h1, 32'h80000200, ST_BUS_ERROR);
    factory_disable = 1'b1;
    user_disable = 1'b1;
    repeat (3) @(negedge ref_clk);
    run(CMD_AES128, 8'h00, 16'h1, SA, ST_FACTORY_OFF);
    factory_disable = 1'b0;
    repeat (3) @(negedge ref_clk);
    run(CMD_AES256, 8'h00, 16'h1, SA, ST_USER_OFF);
    user_disable = 1'b0;
    service_licensed = 1'b0;
    repeat (3) @(negedge ref_clk);
    run(CMD_AES128, 8'h00, 16'h1, SA, ST_NOT_LICENSED);
    finish_test;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    finish_test;
  end
endmodule
